/* File: design/rx_port_input_config_defs.svh */
`ifndef RX_PORT_INPUT_CONFIG_DEFS_SVH
`define RX_PORT_INPUT_CONFIG_DEFS_SVH

// Register offsets
`define ADDR_PORT_SELECT 8'h4c
`define ADDR_INPUT_SETUP 8'h6d
`define ADDR_PIN_SELECT_LOW 8'h6e
`define ADDR_PIN_SELECT_HIGH 8'h6f
`define ADDR_RAW_TEN_MAP 8'h70

// Port select field
`define PORT_SELECT_MSB 1
`define PORT_SELECT_MASK 8'h03

// Input setup field positions
`define BIT_WAIT_ONE 7
`define BIT_WAIT_ANY 6
`define BIT_FWD_CKSUM 5
`define BIT_FWD_ECC 4
`define BIT_LEN_OR_TRUNC 3
`define BIT_RESERVED 2
`define FORMAT_MSB 1

// Reset values
`define RESET_PORT_SELECT 8'h00
`define RESET_SETUP_HIGH 5'h0f
`define RESET_PIN_SELECT 8'h88
`define RESET_RAW_TEN_MAP 8'h00

// Back-channel source codes
`define SRC_CONST_ZERO 4'h8
`define SRC_CONST_ONE 4'h9
`define SRC_FRAME_SYNC 4'ha

// Frame count that ends a first-frame wait
`define FIRST_FRAME_COUNT 16'h0001

`endif

/* File: design/rx_port_pkg.sv */
package rx_port_pkg;

	// Input format of one receive port
	typedef enum logic [1:0] {
		FMT_PACKET = 2'b00,
		FMT_RAW12_LOW = 2'b01,
		FMT_RAW12_HIGH = 2'b10,
		FMT_RAW10 = 2'b11
	} format_t;

	// Packet receiver gate; RX_WAIT_ANY to RX_OPEN flips one bit, RX_WAIT_ONE to RX_OPEN flips both
	typedef enum logic [1:0] {
		RX_WAIT_ONE = 2'b00,
		RX_WAIT_ANY = 2'b01,
		RX_OPEN = 2'b11
	} rx_state_t;

	// Port setup register image, bit 7 first
	typedef struct packed {
		logic waitFirstFrameStartCountOne;
		logic waitAnyFrameStart;
		logic forwardPayloadCheckErrors;
		logic forwardHeaderEccErrors;
		logic lengthOrTruncControl;
		logic reservedBit;
		format_t inputFormatSelect;
	} port_cfg_t;

	// One packet or raw line from a port receiver
	typedef struct packed {
		logic valid;
		logic frameStart;
		logic [15:0] frameCount;
		logic cksumErr;
		logic eccErr;
		logic lenErr;
		logic firstLine;
		logic lineTrunc;
	} pkt_t;

	// Register access strobes from the serial control slave
	typedef struct packed {
		logic write;
		logic read;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_req_t;

endpackage : rx_port_pkg

/* File: design/rx_port_input_config.sv */
`include "rx_port_input_config_defs.svh"

module rx_port_input_config #(
	parameter int NUM_PORTS = 4,
	parameter int PIN_COUNT = 8
) (
	input wire logic clock,
	input wire logic rst,
	input wire rx_port_pkg::reg_req_t regReq,
	output logic [7:0] regRdData,
	output logic regRdValid,
	input wire logic [NUM_PORTS-1:0][1:0] strapFormat,
	input wire logic [NUM_PORTS-1:0] strapReserved,
	input wire logic [PIN_COUNT-1:0] localPins,
	input wire logic internalFrameSync,
	input wire rx_port_pkg::pkt_t [NUM_PORTS-1:0] pktIn,
	output logic [NUM_PORTS-1:0] pktPass,
	output logic [NUM_PORTS-1:0] pktDrop,
	output logic [NUM_PORTS-1:0][3:0] backChannelBits,
	output logic [NUM_PORTS-1:0][7:0] rawTenMap,
	output logic [NUM_PORTS-1:0] rawTenMapActive,
	output rx_port_pkg::port_cfg_t [NUM_PORTS-1:0] portCfg
);

	// ****************************************
	// State
	// ****************************************

	typedef struct packed {
		// Port select, then register copies, one per port
		logic [7:0] portSel;
		rx_port_pkg::port_cfg_t [NUM_PORTS-1:0] cfg;
		logic [NUM_PORTS-1:0][7:0] selLow;
		logic [NUM_PORTS-1:0][7:0] selHigh;
		logic [NUM_PORTS-1:0][7:0] rawMap;
		// Packet gate and per-port outputs
		rx_port_pkg::rx_state_t [NUM_PORTS-1:0] rxState;
		logic [NUM_PORTS-1:0] pass;
		logic [NUM_PORTS-1:0] drop;
		logic [NUM_PORTS-1:0][3:0] bc;
		logic [NUM_PORTS-1:0][7:0] mapOut;
		logic [NUM_PORTS-1:0] mapEn;
		// Read answer
		logic [7:0] rdData;
		logic rdValid;
		// Synchroniser stages
		logic [PIN_COUNT-1:0] pinMeta;
		logic [PIN_COUNT-1:0] pinSync;
		logic [NUM_PORTS-1:0][2:0] strapMeta;
		logic [NUM_PORTS-1:0][2:0] strapSync;
	} state_t;

	state_t st_reg;
	state_t st_next;

	// ****************************************
	// Functions
	// ****************************************

	// Gate state a port returns to after setup changes
	function automatic rx_port_pkg::rx_state_t startState(input rx_port_pkg::port_cfg_t c);
		// count-one wait outranks the plain wait
		if (c.waitFirstFrameStartCountOne) begin
			startState = rx_port_pkg::RX_WAIT_ONE;
		end else if (c.waitAnyFrameStart) begin
			startState = rx_port_pkg::RX_WAIT_ANY;
		end else begin
			startState = rx_port_pkg::RX_OPEN;
		end
	endfunction : startState

	// Value sent for one back-channel bit
	function automatic logic bcSource(input logic [3:0] sel, input logic [PIN_COUNT-1:0] pins,
			input logic fsync);
		logic [7:0] padded;
		// Pins beyond PIN_COUNT read as zero
		padded = 8'h00;
		padded[PIN_COUNT-1:0] = pins;
		if (!sel[3]) begin
			bcSource = padded[sel[2:0]];
		end else begin
			unique case (sel)
				`SRC_CONST_ZERO: bcSource = 1'b0;
				`SRC_CONST_ONE: bcSource = 1'b1;
				`SRC_FRAME_SYNC: bcSource = fsync;
				default: bcSource = 1'b0;
			endcase
		end
	endfunction : bcSource

	// True when the port index in the select register exists
	function automatic logic portValid(input logic [7:0] sel);
		portValid = (32'(sel & `PORT_SELECT_MASK) < NUM_PORTS);
	endfunction : portValid

	// True for the three raw parallel formats
	function automatic logic isRawFormat(input rx_port_pkg::format_t f);
		isRawFormat = (f != rx_port_pkg::FMT_PACKET);
	endfunction : isRawFormat

	// ****************************************
	// Next-state logic
	// ****************************************

	// Index of the port copy the bus reaches
	logic [`PORT_SELECT_MSB:0] sp;
	assign sp = st_reg.portSel[`PORT_SELECT_MSB:0];

	always_comb begin
		// Scratch values for one port of the filter
		logic gateOk;
		logic errDrop;
		logic isRaw;
		rx_port_pkg::pkt_t p;
		rx_port_pkg::port_cfg_t c;
		gateOk = 1'b0;
		errDrop = 1'b0;
		isRaw = 1'b0;
		p = '0;
		c = '0;
		// Every field holds unless assigned below
		st_next = st_reg;

		// Two-flop synchronisers for pins and straps
		st_next.pinMeta = localPins;
		st_next.pinSync = st_reg.pinMeta;
		// Straps feed only the reset load
		for (int i = 0; i < NUM_PORTS; i++) begin
			st_next.strapMeta[i] = {strapReserved[i], strapFormat[i]};
		end
		st_next.strapSync = st_reg.strapMeta;

		// register writes reach the selected port copy
		st_next.rdValid = 1'b0;
		if (regReq.write) begin
			if (regReq.addr == `ADDR_PORT_SELECT) begin
				// Port select keeps only the index bits
				st_next.portSel = regReq.data & `PORT_SELECT_MASK;
			end else if (portValid(st_reg.portSel)) begin
				// Per-port offsets reach only the selected copy
				unique case (regReq.addr)
					`ADDR_INPUT_SETUP: begin
						// format and reserved bit are plain read/write
						st_next.cfg[sp] = rx_port_pkg::port_cfg_t'(regReq.data);
						st_next.rxState[sp] = startState(rx_port_pkg::port_cfg_t'(regReq.data));
					end
					// selectors for bits 0 and 1
					`ADDR_PIN_SELECT_LOW: begin
						st_next.selLow[sp] = regReq.data;
					end
					// selectors for bits 2 and 3
					`ADDR_PIN_SELECT_HIGH: begin
						st_next.selHigh[sp] = regReq.data;
					end
					`ADDR_RAW_TEN_MAP: begin
						st_next.rawMap[sp] = regReq.data;
					end
					// Other offsets belong to other blocks
					default: begin
					end
				endcase
			end
		end

		// read-back from the selected port copy, unmapped reads zero
		if (regReq.read) begin
			// Answer pulse one cycle after the strobe
			st_next.rdValid = 1'b1;
			st_next.rdData = 8'h00;
			if (regReq.addr == `ADDR_PORT_SELECT) begin
				st_next.rdData = st_reg.portSel;
			end else if (portValid(st_reg.portSel)) begin
				// Per-port offsets read the selected copy
				unique case (regReq.addr)
					`ADDR_INPUT_SETUP: st_next.rdData = st_reg.cfg[sp];
					`ADDR_PIN_SELECT_LOW: st_next.rdData = st_reg.selLow[sp];
					`ADDR_PIN_SELECT_HIGH: st_next.rdData = st_reg.selHigh[sp];
					`ADDR_RAW_TEN_MAP: st_next.rdData = st_reg.rawMap[sp];
					// Unmapped offsets read zero
					default: st_next.rdData = 8'h00;
				endcase
			end
		end

		// Per-port packet filter, back channel and map outputs
		for (int i = 0; i < NUM_PORTS; i++) begin
			// Descriptor and setup of this port
			p = pktIn[i];
			c = st_reg.cfg[i];
			isRaw = isRawFormat(c.inputFormatSelect);
			// Outcome pulses last one cycle
			st_next.pass[i] = 1'b0;
			st_next.drop[i] = 1'b0;
			// header ECC errors in every format
			errDrop = p.eccErr && !c.forwardHeaderEccErrors;
			if (isRaw) begin
				// waits and checksum ignored in raw formats
				gateOk = 1'b1;
				errDrop = errDrop || (p.firstLine && p.lineTrunc && c.lengthOrTruncControl);
			end else begin
				// Packet mode gate follows the hunt state
				unique case (st_reg.rxState[i])
					// wait for frame start with count one
					rx_port_pkg::RX_WAIT_ONE: gateOk = p.frameStart && (p.frameCount == `FIRST_FRAME_COUNT);
					rx_port_pkg::RX_WAIT_ANY: gateOk = p.frameStart;
					rx_port_pkg::RX_OPEN: gateOk = 1'b1;
					default: gateOk = 1'b0;
				endcase
				errDrop = errDrop || (p.cksumErr && !c.forwardPayloadCheckErrors);
				errDrop = errDrop || (p.lenErr && !c.lengthOrTruncControl);
				// opening frame start opens gate even if dropped
				if (p.valid && gateOk) begin
					st_next.rxState[i] = rx_port_pkg::RX_OPEN;
				end
			end
			// Exactly one outcome per valid packet
			if (p.valid) begin
				st_next.pass[i] = gateOk && !errDrop;
				st_next.drop[i] = !(gateOk && !errDrop);
			end
			// local pins read after the synchroniser
			st_next.bc[i] = {bcSource(st_reg.selHigh[i][7:4], st_reg.pinSync, internalFrameSync),
				bcSource(st_reg.selHigh[i][3:0], st_reg.pinSync, internalFrameSync),
				bcSource(st_reg.selLow[i][7:4], st_reg.pinSync, internalFrameSync),
				bcSource(st_reg.selLow[i][3:0], st_reg.pinSync, internalFrameSync)};
			// raw ten map only in raw10 format
			st_next.mapEn[i] = (c.inputFormatSelect == rx_port_pkg::FMT_RAW10);
			// Map value reads zero outside raw10
			st_next.mapOut[i] = st_next.mapEn[i] ? st_reg.rawMap[i] : 8'h00;
		end

		// Synchronous reset, straps loaded from synchronised pins
		if (rst) begin
			// Port select and read answer
			st_next.portSel = `RESET_PORT_SELECT;
			st_next.rdData = 8'h00;
			st_next.rdValid = 1'b0;
			for (int i = 0; i < NUM_PORTS; i++) begin
				// reserved bit and format from strap
				st_next.cfg[i] = rx_port_pkg::port_cfg_t'({`RESET_SETUP_HIGH, st_reg.strapSync[i]});
				st_next.rxState[i] = startState(st_next.cfg[i]);
				// selectors reset to the constant-zero source
				st_next.selLow[i] = `RESET_PIN_SELECT;
				st_next.selHigh[i] = `RESET_PIN_SELECT;
				st_next.rawMap[i] = `RESET_RAW_TEN_MAP;
				// No outcome or back-channel value during reset
				st_next.pass[i] = 1'b0;
				st_next.drop[i] = 1'b0;
				st_next.bc[i] = 4'h0;
				st_next.mapOut[i] = 8'h00;
				st_next.mapEn[i] = 1'b0;
			end
		end
	end

	// ****************************************
	// State register
	// ****************************************

	// All state moves on one edge
	always_ff @(posedge clock) begin
		st_reg <= st_next;
	end

	// ****************************************
	// Outputs
	// ****************************************

	// Outputs straight from flops
	assign regRdData = st_reg.rdData;
	assign regRdValid = st_reg.rdValid;
	assign pktPass = st_reg.pass;
	assign pktDrop = st_reg.drop;
	assign backChannelBits = st_reg.bc;
	assign rawTenMap = st_reg.mapOut;
	assign rawTenMapActive = st_reg.mapEn;
	assign portCfg = st_reg.cfg;

endmodule : rx_port_input_config

/* File: verif/rx_port_input_config_properties.sv */
module rx_port_input_config_properties #(
	parameter int NUM_PORTS = 4
) (
	input wire logic clock,
	input wire logic rst,
	input wire rx_port_pkg::reg_req_t regReq,
	input wire logic regRdValid,
	input wire rx_port_pkg::pkt_t [NUM_PORTS-1:0] pktIn,
	input wire logic [NUM_PORTS-1:0] pktPass,
	input wire logic [NUM_PORTS-1:0] pktDrop,
	input wire logic [NUM_PORTS-1:0][7:0] rawTenMap,
	input wire logic [NUM_PORTS-1:0] rawTenMapActive,
	input wire rx_port_pkg::port_cfg_t [NUM_PORTS-1:0] portCfg
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Port zero views
	// ****
	wire rx_port_pkg::pkt_t p = pktIn[0];
	wire rx_port_pkg::port_cfg_t c = portCfg[0];
	wire raw = c.inputFormatSelect != rx_port_pkg::FMT_PACKET;
	wire cut = p.firstLine && p.lineTrunc && c.lengthOrTruncControl;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Register answers, packet outcomes and raw ten map
	AST_READ_ANSWER:
		assert property (regReq.read |=> regRdValid) else $error("read unanswered");
	AST_READ_QUIET:
		assert property (!regReq.read |=> !regRdValid) else $error("stray read valid");
	AST_ONE_FATE:
		assert property (p.valid |=> pktPass[0] != pktDrop[0]) else $error("bad packet fate");
	AST_CKSUM_DROP:
		assert property (p.valid && !raw && p.cksumErr && !c.forwardPayloadCheckErrors |=> pktDrop[0])
			else $error("checksum packet kept");
	AST_ECC_DROP:
		assert property (p.valid && p.eccErr && !c.forwardHeaderEccErrors |=> pktDrop[0])
			else $error("ecc packet kept");
	AST_LEN_DROP:
		assert property (p.valid && !raw && p.lenErr && !c.lengthOrTruncControl |=> pktDrop[0])
			else $error("length packet kept");
	AST_TRUNC_DROP:
		assert property (p.valid && raw && cut |=> pktDrop[0]) else $error("cut line kept");
	AST_RAW_PASS:
		assert property (p.valid && raw && !p.eccErr && !cut |=> pktPass[0]) else $error("raw line lost");
	AST_MAP_IDLE:
		assert property (!rawTenMapActive[0] |-> rawTenMap[0] == 8'h00) else $error("map leaks");
	AST_MAP_ON:
		assert property (c.inputFormatSelect == rx_port_pkg::FMT_RAW10 |=> rawTenMapActive[0])
			else $error("map not enabled in raw10");
	AST_MAP_OFF:
		assert property (c.inputFormatSelect != rx_port_pkg::FMT_RAW10 |=> !rawTenMapActive[0])
			else $error("map enabled outside raw10");
endmodule : rx_port_input_config_properties

bind rx_port_input_config rx_port_input_config_properties #(.NUM_PORTS(NUM_PORTS)) chk_u (
	.clock(clock), .rst(rst), .regReq(regReq), .regRdValid(regRdValid), .pktIn(pktIn), .pktPass(pktPass),
	.pktDrop(pktDrop), .rawTenMap(rawTenMap), .rawTenMapActive(rawTenMapActive), .portCfg(portCfg)
);

/* File: verif/serial_link_partner.sv */
module serial_link_partner #(
	parameter int NUM_PORTS = 4
) (
	input wire logic clock,
	output rx_port_pkg::pkt_t [NUM_PORTS-1:0] pktOut
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Remote packet source
	// ****
	initial begin
		pktOut = '0;
	end
	// One packet on port zero, then scrambled idle fields
	task automatic send(input logic fs, input logic [15:0] cnt, input logic [4:0] e);
		rx_port_pkg::pkt_t q;
		@(negedge clock);
		pktOut[0] = {1'b1, fs, cnt, e};
		@(negedge clock);
		q = ~pktOut[0];
		q.valid = 1'b0;
		pktOut[0] = q;
	endtask : send
endmodule : serial_link_partner

/* File: verif/rx_port_input_config_tb_top.sv */
module rx_port_input_config_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Stimulus and scoreboard
	// ****
	logic clock = 1'b0;
	logic rst = 1'b1;
	rx_port_pkg::reg_req_t regReq = '0;
	logic [7:0] regRdData;
	logic regRdValid;
	logic [3:0][1:0] strapFormat = '0;
	logic [3:0] strapReserved = '0;
	logic [7:0] localPins = '0;
	logic internalFrameSync = 1'b0;
	rx_port_pkg::pkt_t [3:0] pktIn;
	logic [3:0] pktPass;
	logic [3:0] pktDrop;
	logic [3:0][3:0] backChannelBits;
	logic [3:0][7:0] rawTenMap;
	logic [3:0] rawTenMapActive;
	rx_port_pkg::port_cfg_t [3:0] portCfg;
	logic [7:0] rdQ[$];
	logic pkQ[$];
	int errCount = 0;
	int cmpCount = 0;
	logic [7:0] cfg0;
	int f;

	always #50 clock = ~clock;

	rx_port_input_config dut_u (.clock(clock), .rst(rst), .regReq(regReq), .regRdData(regRdData),
		.regRdValid(regRdValid), .strapFormat(strapFormat), .strapReserved(strapReserved),
		.localPins(localPins), .internalFrameSync(internalFrameSync), .pktIn(pktIn), .pktPass(pktPass),
		.pktDrop(pktDrop), .backChannelBits(backChannelBits), .rawTenMap(rawTenMap),
		.rawTenMapActive(rawTenMapActive), .portCfg(portCfg));
	serial_link_partner link_u (.clock(clock), .pktOut(pktIn));

	// Compare helpers
	task automatic cmpData(input logic [7:0] e, input logic [7:0] a);
		cmpCount++;
		if (a !== e) begin
			errCount++;
			$display("Error at %0t: expected %h got %h", $time, e, a);
		end
	endtask : cmpData
	task automatic cmpFate(input logic e, input logic a);
		cmpData({7'h00, e}, {7'h00, a});
	endtask : cmpFate
	// Bus and packet drivers noting expected results
	task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		regReq = {w, r, a, d};
		@(negedge clock);
		regReq = '0;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rdQ.push_back(e);
		bus(1'b0, 1'b1, a, 8'h00);
	endtask : rd
	task automatic pk(input logic fs, input logic [15:0] n, input logic [4:0] e, input logic x);
		pkQ.push_back(x);
		link_u.send(fs, n, e);
	endtask : pk
	// Verdict
	task automatic endSim;
		errCount += rdQ.size() + pkQ.size();
		$display("Mismatches %0d, comparisons %0d", errCount, cmpCount);
		if (errCount == 0 && cmpCount > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : endSim

	// Results matched against oldest notes
	always @(negedge clock) begin
		if (regRdValid === 1'b1)
			cmpData(rdQ.size() ? rdQ.pop_front() : 8'hxx, regRdData);
		if ((pktPass[0] | pktDrop[0]) === 1'b1)
			cmpFate(pkQ.size() ? pkQ.pop_front() : 1'bx, pktPass[0]);
	end

	// Watchdog
	initial begin
		#(2000 * 100);
		errCount++;
		endSim();
	end

	// Main sequence
	initial begin
		void'($urandom(709));
		strapFormat = 8'($urandom);
		strapReserved = 4'($urandom);
		localPins = 8'($urandom);
		internalFrameSync = 1'b1;
		repeat (10) @(negedge clock);
		rst = 1'b0;
		cfg0 = {5'h0f, strapReserved[0], strapFormat[0]};
		rd(8'h6d, cfg0);
		rd(8'h6e, 8'h88);
		rd(8'h4c, 8'h00);
		rd(8'h55, 8'h00);
		cmpData(8'h00, {4'h0, backChannelBits[0]});
		wr(8'h4c, 8'h02);
		wr(8'h6d, 8'h12);
		rd(8'h6d, 8'h12);
		cmpData(8'h12, portCfg[2]);
		wr(8'h4c, 8'h00);
		rd(8'h6d, cfg0);
		wr(8'h6e, 8'h9a);
		wr(8'h6f, 8'hc3);
		rd(8'h6e, 8'h9a);
		for (f = 0; f < 2; f++) begin
			repeat (4) @(negedge clock);
			cmpData({5'h00, localPins[3], 1'b1, internalFrameSync}, {4'h0, backChannelBits[0]});
			localPins = ~localPins;
			internalFrameSync = ~internalFrameSync;
		end
		wr(8'h6d, 8'hb8);
		pk(1'b0, 16'h0000, 5'h00, 1'b0);
		pk(1'b1, 16'h0002, 5'h00, 1'b0);
		pk(1'b1, 16'h0001, 5'h00, 1'b1);
		pk(1'b0, 16'h0000, 5'h1c, 1'b1);
		wr(8'h6d, 8'h40);
		pk(1'b0, 16'h0000, 5'h00, 1'b0);
		pk(1'b1, 16'h0005, 5'h00, 1'b1);
		pk(1'b0, 16'h0000, 5'h10, 1'b0);
		pk(1'b0, 16'h0000, 5'h08, 1'b0);
		pk(1'b0, 16'h0000, 5'h04, 1'b0);
		for (f = 1; f < 4; f++) begin
			wr(8'h6d, 8'hc8 | 8'(f));
			pk(1'b0, 16'h0000, 5'h10, 1'b1);
			pk(1'b0, 16'h0000, 5'h03, 1'b0);
			cmpData({6'h00, 2'(f)}, {6'h00, portCfg[0].inputFormatSelect});
			cmpFate(f == 3, rawTenMapActive[0]);
		end
		wr(8'h70, 8'h5a);
		repeat (2) @(negedge clock);
		cmpData(8'h5a, rawTenMap[0]);
		wr(8'h6d, 8'h03);
		pk(1'b0, 16'h0000, 5'h03, 1'b1);
		repeat (3) @(negedge clock);
		endSim();
	end
endmodule : rx_port_input_config_tb_top
